// >>> rtl/led_intensity_blink_pwm.sv
// Summary of operation
// (RQ1) setting n below 0xF, phase bit 0: port low (n+1)/16, else released
// (RQ2) phase bit 1 inverts the pwm polarity for settings 0x0 to 0xE
// (RQ3) setting 0xF: static low with phase bit 0, static released with 1
// (RQ4) phase bits 0 then 1: low settings dim then bright, high opposite
// (RQ5) setting 0x7 gives half intensity in both blink phases
// (RQ6) phase bits 1 then 0 with 0xF: off in phase 0, on in phase 1
// (RQ7) register at command 0x0E holds master high nibble, global low nibble
// (RQ8) host writes the register and reads back the stored value
// (RQ9) master zero stops the oscillator, outputs static without pwm
// (RQ10) master m gives a master duty of m fifteenths
// (RQ11) master all ones gives full window, outputs follow own setting
// (RQ12) low nibble g below 15 gives the extra output (g+1)/16 of window
// (RQ13) low nibble all ones makes the extra output a static level
// (RQ14) global flag applies the low nibble to every output
// (RQ15) global control covers all ports together, individual mode mixes static
// (RQ16) all outputs share one counter and one pwm cycle start
`timescale 1ns/1ps
module led_intensity_blink_pwm
  import lib_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR  = SLAVE_ADDR_DEF,
  parameter int         TICK_CYCLES = TICK_CYCLES_DEF
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  input  wire logic                          sclIn,
  input  wire logic                          sdaIn,
  output logic                               sdaOut,
  output logic                               sdaOe,
  input  wire logic [NUM_PORTS*LEVEL_W-1:0]  portIntensity,
  input  wire logic                          globalIntensityEn,
  input  wire logic                          blinkPhase,
  input  wire logic [NUM_OUTS-1:0]           blinkPhase0Bits,
  input  wire logic [NUM_OUTS-1:0]           blinkPhase1Bits,
  output logic      [NUM_PORTS-1:0]          portPinsOut,
  output logic      [NUM_PORTS-1:0]          portPinsOe,
  output logic                               extraOutputPinOut,
  output logic                               extraOutputPinOe,
  output logic      [7:0]                    masterGlobalIntensity,
  output logic                               oscRunning
);
  import lib_pkg::*;

  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  // ---------------- serial slave ----------------
  logic [1:0] busLevel;
  logic       sclLvl;
  logic       sdaLvl;
  logic       sclPrev_r;
  logic       sdaPrev_r;
  logic       sclRise;
  logic       sclFall;
  logic       startCond;
  logic       stopCond;

  lib_sync #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .asyncIn  ({sclIn, sdaIn}),
    .levelOut (busLevel)
  );

  assign sclLvl    = busLevel[1];
  assign sdaLvl    = busLevel[0];
  assign sclRise   = sclLvl && !sclPrev_r;
  assign sclFall   = !sclLvl && sclPrev_r;
  assign startCond = sclLvl && sclPrev_r && sdaPrev_r && !sdaLvl;
  assign stopCond  = sclLvl && sclPrev_r && !sdaPrev_r && sdaLvl;

  lib_ser_st_e st_r;
  lib_ser_st_e st_nxt;
  lib_ser_st_e afterAck_r;
  lib_ser_st_e afterAck_nxt;
  logic [3:0]  bitCnt_r;
  logic [3:0]  bitCnt_nxt;
  logic [7:0]  shift_r;
  logic [7:0]  shift_nxt;
  logic [7:0]  cmd_r;
  logic [7:0]  cmd_nxt;
  logic        nack_r;
  logic        nack_nxt;
  logic        sdaOe_r;
  logic        sdaOe_nxt;
  logic [7:0]  intens_r;
  logic [7:0]  intens_nxt;
  logic [7:0]  readData;

  // only the master and global register is mapped; other commands read zero
  assign readData = (cmd_r == REG_MASTER_GLOBAL) ? intens_r : READ_UNMAPPED_VALUE;  // see (RQ8)

  always_comb begin
    st_nxt       = st_r;
    afterAck_nxt = afterAck_r;
    bitCnt_nxt   = bitCnt_r;
    shift_nxt    = shift_r;
    cmd_nxt      = cmd_r;
    nack_nxt     = nack_r;
    sdaOe_nxt    = sdaOe_r;
    intens_nxt   = intens_r;
    if (startCond) begin
      // a repeated start keeps the command byte for a following read
      st_nxt     = ST_ADDR;
      bitCnt_nxt = 4'h0;
      sdaOe_nxt  = 1'b0;
    end else if (stopCond) begin
      st_nxt    = ST_IDLE;
      sdaOe_nxt = 1'b0;
    end else if (sclRise) begin
      if (st_r == ST_ADDR || st_r == ST_CMD || st_r == ST_WDAT) begin
        shift_nxt  = {shift_r[6:0], sdaLvl};
        bitCnt_nxt = bitCnt_r + 4'h1;
      end else if (st_r == ST_RDAT) begin
        bitCnt_nxt = bitCnt_r + 4'h1;
      end else if (st_r == ST_MACK) begin
        nack_nxt = sdaLvl;
      end
    end else if (sclFall) begin
      unique case (st_r)
        ST_IDLE: begin
          sdaOe_nxt = 1'b0;
        end
        ST_ADDR: begin
          if (bitCnt_r == BYTE_BITS) begin
            bitCnt_nxt = 4'h0;
            if (shift_r[7:1] == SLAVE_ADDR) begin
              sdaOe_nxt    = 1'b1;
              st_nxt       = ST_ACK;
              afterAck_nxt = shift_r[0] ? ST_RDAT : ST_CMD;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (bitCnt_r == BYTE_BITS) begin
            cmd_nxt      = shift_r;
            sdaOe_nxt    = 1'b1;
            st_nxt       = ST_ACK;
            afterAck_nxt = ST_WDAT;
          end
        end
        ST_WDAT: begin
          if (bitCnt_r == BYTE_BITS) begin
            if (cmd_r == REG_MASTER_GLOBAL) begin
              intens_nxt = shift_r;  // see (RQ7) see (RQ8)
            end
            sdaOe_nxt    = 1'b1;
            st_nxt       = ST_ACK;
            afterAck_nxt = ST_WDAT;
          end
        end
        ST_ACK: begin
          bitCnt_nxt = 4'h0;
          st_nxt     = afterAck_r;
          if (afterAck_r == ST_RDAT) begin
            shift_nxt = readData;
            sdaOe_nxt = !readData[7];
          end else begin
            sdaOe_nxt = 1'b0;
          end
        end
        ST_RDAT: begin
          if (bitCnt_r == BYTE_BITS) begin
            sdaOe_nxt = 1'b0;
            st_nxt    = ST_MACK;
          end else begin
            shift_nxt = {shift_r[6:0], 1'b0};
            sdaOe_nxt = !shift_r[6];
          end
        end
        ST_MACK: begin
          if (nack_r) begin
            st_nxt    = ST_IDLE;
            sdaOe_nxt = 1'b0;
          end else begin
            bitCnt_nxt = 4'h0;
            shift_nxt  = readData;
            sdaOe_nxt  = !readData[7];
            st_nxt     = ST_RDAT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r       <= ST_IDLE;
      afterAck_r <= ST_IDLE;
      bitCnt_r   <= 4'h0;
      shift_r    <= 8'h00;
      cmd_r      <= 8'h00;
      nack_r     <= 1'b1;
      sdaOe_r    <= 1'b0;
      intens_r   <= MASTER_GLOBAL_RST;
      sclPrev_r  <= 1'b1;
      sdaPrev_r  <= 1'b1;
    end else begin
      st_r       <= st_nxt;
      afterAck_r <= afterAck_nxt;
      bitCnt_r   <= bitCnt_nxt;
      shift_r    <= shift_nxt;
      cmd_r      <= cmd_nxt;
      nack_r     <= nack_nxt;
      sdaOe_r    <= sdaOe_nxt;
      intens_r   <= intens_nxt;
      sclPrev_r  <= sclLvl;
      sdaPrev_r  <= sdaLvl;
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_r;
  assign masterGlobalIntensity = intens_r;

  // ---------------- shared pwm timebase ----------------
  logic [3:0]  masterLevel;
  logic [3:0]  globalLevel;
  logic        running;
  logic [15:0] tickCnt_r;
  logic [15:0] tickCnt_nxt;
  logic [3:0]  masterCnt_r;
  logic [3:0]  masterCnt_nxt;
  logic [3:0]  slot_r;
  logic [3:0]  slot_nxt;

  assign masterLevel = intens_r[MASTER_MSB:MASTER_LSB];  // see (RQ7)
  assign globalLevel = intens_r[GLOBAL_MSB:GLOBAL_LSB];  // see (RQ7)
  assign running     = (masterLevel != MASTER_OFF);      // see (RQ9)

  // each sub-slot spans fifteen master steps so the master gate repeats inside it
  always_comb begin
    tickCnt_nxt   = tickCnt_r;
    masterCnt_nxt = masterCnt_r;
    slot_nxt      = slot_r;
    if (!running) begin
      // oscillator held off; every counter parks at cycle start
      tickCnt_nxt   = 16'h0000;  // see (RQ9)
      masterCnt_nxt = 4'h0;
      slot_nxt      = 4'h0;
    end else if (tickCnt_r == TICK_LAST) begin
      tickCnt_nxt = 16'h0000;
      if (masterCnt_r == MASTER_LAST) begin
        masterCnt_nxt = 4'h0;
        slot_nxt      = slot_r + 4'h1;  // see (RQ16)
      end else begin
        masterCnt_nxt = masterCnt_r + 4'h1;
      end
    end else begin
      tickCnt_nxt = tickCnt_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tickCnt_r   <= 16'h0000;
      masterCnt_r <= 4'h0;
      slot_r      <= 4'h0;
    end else begin
      tickCnt_r   <= tickCnt_nxt;
      masterCnt_r <= masterCnt_nxt;
      slot_r      <= slot_nxt;
    end
  end

  lib_pwm_if pwmBus ();

  assign pwmBus.slot    = slot_r;
  // master m opens the gate for m of fifteen steps; 0xF keeps it open
  assign pwmBus.gate    = (masterCnt_r < masterLevel);  // see (RQ10) see (RQ11)
  assign pwmBus.running = running;  // see (RQ9)
  assign oscRunning     = running;

  // ---------------- per-output drive ----------------
  logic [NUM_OUTS-1:0] lowDrive;
  logic [NUM_OUTS-1:0] phaseBits;

  // the blink phase in force picks which bit set steers polarity
  assign phaseBits = blinkPhase ? blinkPhase1Bits : blinkPhase0Bits;

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    logic [3:0] lvl;
    // global mode overrides every port at once, no per-port mixing
    assign lvl = globalIntensityEn ? globalLevel                    // see (RQ14) see (RQ15)
                                   : portIntensity[i*LEVEL_W +: LEVEL_W];
    lib_port_pwm u_port (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .pwm      (pwmBus.sink),
      .level    (lvl),
      .phaseBit (phaseBits[i]),
      .lowDrive (lowDrive[i])
    );
  end

  lib_port_pwm u_extra (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .pwm      (pwmBus.sink),
    .level    (globalLevel),  // see (RQ12) see (RQ13)
    .phaseBit (phaseBits[NUM_OUTS-1]),
    .lowDrive (lowDrive[NUM_OUTS-1])
  );

  // open drain: only ever pull low
  assign portPinsOut       = '0;
  assign portPinsOe        = lowDrive[NUM_PORTS-1:0];
  assign extraOutputPinOut = 1'b0;
  assign extraOutputPinOe  = lowDrive[NUM_OUTS-1];

endmodule

// >>> rtl/lib_pkg.sv
package lib_pkg;

  // serial register map
  localparam logic [7:0] REG_MASTER_GLOBAL   = 8'h0E;
  localparam logic [7:0] MASTER_GLOBAL_RST   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED_VALUE = 8'h00;

  // field layout of the master and global intensity register
  localparam int MASTER_MSB = 7;
  localparam int MASTER_LSB = 4;
  localparam int GLOBAL_MSB = 3;
  localparam int GLOBAL_LSB = 0;

  // pwm structure
  localparam int          LEVEL_W       = 4;
  localparam int          MASTER_STEPS  = 15;
  localparam int          SUB_SLOTS     = 16;
  localparam logic [3:0]  MASTER_LAST   = 4'hE;
  localparam logic [3:0]  SLOT_LAST     = 4'hF;
  localparam logic [3:0]  STATIC_CODE   = 4'hF;
  localparam logic [3:0]  MASTER_OFF    = 4'h0;
  localparam int          NUM_PORTS     = 16;
  localparam int          NUM_OUTS      = 17;

  // serial slave
  localparam logic [6:0]  SLAVE_ADDR_DEF = 7'h20;
  localparam logic [3:0]  BYTE_BITS      = 4'h8;
  localparam int          TICK_CYCLES_DEF = 64;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_CMD  = 7'h04,
    ST_WDAT = 7'h08,
    ST_ACK  = 7'h10,
    ST_RDAT = 7'h20,
    ST_MACK = 7'h40
  } lib_ser_st_e;

endpackage

// >>> rtl/lib_pwm_if.sv
`timescale 1ns/1ps
interface lib_pwm_if;
  logic [3:0] slot;
  logic       gate;
  logic       running;

  modport src (
    output slot,
    output gate,
    output running
  );

  modport sink (
    input slot,
    input gate,
    input running
  );
endinterface

// >>> rtl/lib_sync.sv
`timescale 1ns/1ps
module lib_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] levelOut
);
  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // a change counts only once the second and third stages agree
  always_comb begin
    level_nxt = level_r;
    for (int i = 0; i < WIDTH; i++) begin
      if (stage2_r[i] == stage3_r[i]) begin
        level_nxt[i] = stage2_r[i];
      end
    end
  end

  // idle bus level is high
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage1_r <= '1;
      stage2_r <= '1;
      stage3_r <= '1;
      level_r  <= '1;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r  <= level_nxt;
    end
  end

  assign levelOut = level_r;
endmodule

// >>> rtl/lib_port_pwm.sv
`timescale 1ns/1ps
module lib_port_pwm
  import lib_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  lib_pwm_if.sink                   pwm,
  input  wire logic [LEVEL_W-1:0]   level,
  input  wire logic                 phaseBit,
  output logic                      lowDrive
);
  logic pwmLow;
  logic lowDrive_r;
  logic lowDrive_nxt;

  // on time is level+1 sixteenths of the master-gated window
  always_comb begin
    pwmLow = pwm.running && pwm.gate && (pwm.slot <= level);  // see (RQ1) see (RQ16)
    if (level == STATIC_CODE) begin
      lowDrive_nxt = !phaseBit;  // see (RQ3) see (RQ6)
    end else if (phaseBit) begin
      lowDrive_nxt = !pwmLow;  // see (RQ2) see (RQ4) see (RQ5)
    end else begin
      lowDrive_nxt = pwmLow;  // see (RQ1) see (RQ4) see (RQ5)
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lowDrive_r <= 1'b0;
    end else begin
      lowDrive_r <= lowDrive_nxt;
    end
  end

  assign lowDrive = lowDrive_r;
endmodule

// >>> testbench/lib_pwm_checker.sv
`timescale 1ns/1ps
module lib_pwm_checker
  import lib_pkg::*;
(
  input wire logic                         sys_clk,
  input wire logic                         rst,
  input wire logic                         sdaOut,
  input wire logic                         sdaOe,
  input wire logic [NUM_PORTS*LEVEL_W-1:0] portIntensity,
  input wire logic                         globalIntensityEn,
  input wire logic                         blinkPhase,
  input wire logic [NUM_OUTS-1:0]          blinkPhase0Bits,
  input wire logic [NUM_OUTS-1:0]          blinkPhase1Bits,
  input wire logic [NUM_PORTS-1:0]         portPinsOut,
  input wire logic [NUM_PORTS-1:0]         portPinsOe,
  input wire logic                         extraOutputPinOut,
  input wire logic                         extraOutputPinOe,
  input wire logic [7:0]                   masterGlobalIntensity,
  input wire logic                         oscRunning
);
  logic [3:0] mst;
  logic [3:0] glb;
  logic       ph0;
  logic       ph16;
  assign mst = masterGlobalIntensity[7:4];
  assign glb = masterGlobalIntensity[3:0];
  assign ph0 = blinkPhase ? blinkPhase1Bits[0] : blinkPhase0Bits[0];
  assign ph16 = blinkPhase ? blinkPhase1Bits[16] : blinkPhase0Bits[16];
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_osc_from_master: assert property (oscRunning == (mst != 4'h0))
    else $error("oscillator disagrees with master nibble");
  a_reset_clears: assert property ($past(rst) |-> masterGlobalIntensity == 8'h00 && !sdaOe)
    else $error("register or ack not cleared by reset");
  a_write_with_ack: assert property (!$past(rst) && $changed(masterGlobalIntensity) |-> sdaOe)
    else $error("register changed outside an acked byte");
  a_extra_static_full: assert property (!$past(rst) && $past(glb == 4'hF)
    |-> extraOutputPinOe == !$past(ph16)) else $error("extra output not static");
  a_port_static_full: assert property (!$past(rst)
    && $past(!globalIntensityEn && portIntensity[3:0] == 4'hF)
    |-> portPinsOe[0] == !$past(ph0)) else $error("port not static");
  a_global_static_full: assert property (!$past(rst)
    && $past(globalIntensityEn && glb == 4'hF)
    |-> portPinsOe[0] == !$past(ph0)) else $error("global static not applied");
  a_master_off_idle: assert property (!$past(rst) && $past(mst == 4'h0 && glb != 4'hF)
    |-> extraOutputPinOe == $past(ph16)) else $error("modulation while master off");
  a_shared_cycle: assert property (!$past(rst)
    && $past((globalIntensityEn || portIntensity[3:0] == glb) && ph0 == ph16)
    |-> portPinsOe[0] == extraOutputPinOe) else $error("outputs out of step");
  a_pins_drive_low: assert property (portPinsOut == '0 && !extraOutputPinOut && !sdaOut)
    else $error("open drain pin driven high");
  cover property (oscRunning && globalIntensityEn);
  cover property (mst == 4'h0 && glb != 4'hF);
  cover property (sdaOe && $changed(masterGlobalIntensity));
endmodule

bind led_intensity_blink_pwm lib_pwm_checker chk_u (.sys_clk, .rst, .sdaOut, .sdaOe,
  .portIntensity, .globalIntensityEn, .blinkPhase, .blinkPhase0Bits, .blinkPhase1Bits,
  .portPinsOut, .portPinsOe, .extraOutputPinOut, .extraOutputPinOe,
  .masterGlobalIntensity, .oscRunning);

// >>> testbench/lib_host_model.sv
`timescale 1ns/1ps
module lib_host_model
  import lib_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sdaLine,
  output logic      scl,
  output logic      sdaLow
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // half period of ten clocks leaves room for the pin synchroniser
  task automatic hp();
    repeat (10) @(posedge sys_clk);
    #1;
  endtask
  task automatic bitOut(input logic b);
    sdaLow = !b;
    hp();
    scl = 1'b1;
    hp();
    scl = 1'b0;
  endtask
  task automatic bitIn(output logic b);
    sdaLow = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    b = sdaLine;
    scl = 1'b0;
  endtask
  task automatic byteOut(input logic [7:0] b);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bitOut(b[i]);
    end
    bitIn(a);
    if (a !== 1'b0) nacks++;
  endtask
  // sda released with scl low first, so a held ack cannot look like a stop
  task automatic start();
    sdaLow = 1'b0;
    hp();
    scl = 1'b1;
    hp();
    sdaLow = 1'b1;
    hp();
    scl = 1'b0;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    hp();
    scl = 1'b1;
    hp();
    sdaLow = 1'b0;
    hp();
  endtask
  task automatic writeReg(input logic [7:0] cmd, input logic [7:0] dat);
    start();
    byteOut({SLAVE_ADDR_DEF, 1'b0});
    byteOut(cmd);
    byteOut(dat);
    stop();
  endtask
  task automatic readReg(input logic [7:0] cmd, output logic [7:0] dat);
    start();
    byteOut({SLAVE_ADDR_DEF, 1'b0});
    byteOut(cmd);
    start();
    byteOut({SLAVE_ADDR_DEF, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      bitIn(dat[i]);
    end
    bitOut(1'b1);
    stop();
  endtask
endmodule

// >>> testbench/led_intensity_blink_pwm_tb_top.sv
`timescale 1ns/1ps
module led_intensity_blink_pwm_tb_top;
  import lib_pkg::*;
  localparam int TK = 2;
  localparam int PER = SUB_SLOTS * MASTER_STEPS * TK;
  logic                         sys_clk;
  logic                         rst;
  logic                         scl;
  logic                         sdaLow;
  logic                         sdaOe;
  logic [NUM_PORTS*LEVEL_W-1:0] portIntensity;
  logic                         globalIntensityEn;
  logic                         blinkPhase;
  logic [NUM_OUTS-1:0]          blinkPhase0Bits;
  logic [NUM_OUTS-1:0]          blinkPhase1Bits;
  logic [NUM_PORTS-1:0]         portPinsOe;
  logic                         extraOutputPinOe;
  logic                         oscRunning;
  logic [7:0]                   rd;
  wire                          sdaLine;
  int num_errors = 0;
  int samples_checked = 0;
  int seed = 32'h4cdb;
  int c0;
  int c16;
  int m;
  int g;
  int n;
  assign sdaLine = !(sdaLow || sdaOe);
  led_intensity_blink_pwm #(.TICK_CYCLES(TK)) dut_u (.sys_clk, .rst, .sclIn(scl),
    .sdaIn(sdaLine), .sdaOut(), .sdaOe, .portIntensity, .globalIntensityEn, .blinkPhase,
    .blinkPhase0Bits, .blinkPhase1Bits, .portPinsOut(), .portPinsOe, .extraOutputPinOut(),
    .extraOutputPinOe, .masterGlobalIntensity(), .oscRunning);
  lib_host_model host_u (.sys_clk, .sdaLine, .scl, .sdaLow);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic chkVal(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkCnt(input string what, input int exp, input int got);
    samples_checked++;
    if (got != exp) begin
      num_errors++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // low clocks per pwm cycle; a phase bit of 1 inverts the whole gated wave
  function automatic int expLow(input int s, input int b, input int mm);
    int on;
    on = (s == 15) ? PER : (s + 1) * mm * TK;
    return b ? PER - on : on;
  endfunction
  task automatic measure();
    c0 = 0;
    c16 = 0;
    repeat (PER) begin
      @(posedge sys_clk);
      #1;
      c0 += (portPinsOe[0] === 1'b1);
      c16 += (extraOutputPinOe === 1'b1);
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    rst = 1'b1;
    portIntensity = '0;
    globalIntensityEn = 1'b0;
    blinkPhase = 1'b0;
    blinkPhase0Bits = '0;
    blinkPhase1Bits = '0;
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    host_u.readReg(REG_MASTER_GLOBAL, rd);
    chkVal("reset value", MASTER_GLOBAL_RST, rd);
    host_u.writeReg(8'h10, 8'h5A);
    host_u.readReg(8'h10, rd);
    chkVal("other command", READ_UNMAPPED_VALUE, rd);
    host_u.readReg(REG_MASTER_GLOBAL, rd);
    chkVal("register kept", MASTER_GLOBAL_RST, rd);
    $display("register access test done");
    for (int i = 0; i < 32; i++) begin
      m = (i == 0) ? 0 : (i == 1) ? 15 : {$random(seed)} % 16;
      g = i % 16;
      n = (i * 7 + 3) % 16;
      portIntensity = {$random(seed), $random(seed)};
      portIntensity[3:0] = n[3:0];
      globalIntensityEn = (i % 4 == 3);
      blinkPhase = 1'($random(seed));
      blinkPhase0Bits = 17'($random(seed));
      blinkPhase1Bits = 17'($random(seed));
      host_u.writeReg(REG_MASTER_GLOBAL, {m[3:0], g[3:0]});
      host_u.readReg(REG_MASTER_GLOBAL, rd);
      chkVal("master and global", {m[3:0], g[3:0]}, rd);
      chkVal("oscillator", {7'h00, m != 0}, {7'h00, oscRunning});
      measure();
      chkCnt("port 0 low time", expLow(globalIntensityEn ? g : n,
        blinkPhase ? blinkPhase1Bits[0] : blinkPhase0Bits[0], m), c0);
      chkCnt("extra output low time", expLow(g,
        blinkPhase ? blinkPhase1Bits[16] : blinkPhase0Bits[16], m), c16);
      $display("pwm test %0d done", i);
    end
    chkCnt("missing acks", 0, host_u.nacks);
    report_and_stop();
  end
endmodule
